// >>> qsf_pkg.sv
// Functional notes
// R1: Single or dual lane drives data line 2 from the write-protect bit.
// R2: Single or dual lane drives data line 3 from the hold bit.
// R3: Flash clocking mode ignores polarity/phase; send and sample on falling edge.
// R4: During transmit, received bytes enter receive FIFO only if latch bit set.
// R5: Low-bit-first selects LSB first, otherwise MSB first, both directions.
// R6: Idle serial clock level equals the polarity bit.
// R7: Phase set toggles at bit start; clear toggles at bit middle.
// R8: Mode field: 001 CPU, 010 DMA, 011 execute-in-place; others reserved.
// R9: Leaving execute-in-place mode always lands in CPU mode.
// R10: Execute-in-place mode uses programmed register timing like other modes.
// R11: Release bit set frees chip select after byte count; clear keeps it.
// R12: Target select 00 device 0, 01 device 1; others reserved.
// R13: Lane width 00 single, 01 dual, 10 quad; 11 reserved.
// R14: Command initiation 00 idle, 01 transmit, 10 receive; 11 reserved.
// R15: Transmit bytes start from transmit data writes or FIFO content.
// R16: Receive bytes start from receive data reads or FIFO room.
// R17: Sixteen-bit byte count sets total bytes in the chosen direction.
// R18: Divider zero divides base clock by 2; bit k divides by 2^(k+2).
// R19: Clock-stable flag rises after enable once the serial clock settles.
// R20: Clearing clock enable stops serial clock; registers stay reachable.
// R21: Transmit starts once transmit FIFO holds threshold bytes.
// R22: Receive starts only when receive FIFO has room for threshold bytes.
// R23: Software keeps both thresholds even in sixteen-bit operation.
// R24: Self-clearing soft reset bit pulses reset of engines and FIFO pointers.
// R25: Reserved field encodings start nothing and leave the interface idle.
package qsf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_XFER = 8'h04;
  localparam logic [7:0] OFS_CLK = 8'h08;
  localparam logic [7:0] OFS_THR = 8'h0C;
  localparam logic [7:0] OFS_TXD = 8'h10;
  localparam logic [7:0] OFS_RXD = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CLOCK_PHASE = 3;
  localparam int CFG_CLOCK_POLARITY = 4;
  localparam int CFG_LOW_BIT_FIRST = 5;
  localparam int CFG_RXL = 7;
  localparam int CFG_FLASH = 8;
  localparam int CFG_WP = 9;
  localparam int CFG_HOLD = 10;
  localparam int CFG_RST = 16;
  localparam logic [31:0] CFG_WMASK = 32'h000007BF;
  localparam int XF_CNT_LSB = 0;
  localparam int XF_INIT_LSB = 16;
  localparam int XF_LANE_LSB = 18;
  localparam int XF_DEV_LSB = 20;
  localparam int XF_REL = 22;
  localparam logic [31:0] XF_WMASK = 32'h007FFFFF;
  localparam int CK_EN = 0;
  localparam int CK_STABLE = 1;
  localparam int CK_DIV_LSB = 8;
  localparam int TH_RX_LSB = 0;
  localparam int TH_TX_LSB = 8;
  // Reset values
  localparam logic [31:0] REG_RST_VAL = 32'h00000000;
  // Field codes
  localparam logic [2:0] MODE_CPU = 3'h1;
  localparam logic [2:0] MODE_DMA = 3'h2;
  localparam logic [2:0] MODE_XIP = 3'h3;
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  localparam logic [1:0] INIT_IDLE = 2'h0;
  localparam logic [1:0] INIT_TX = 2'h1;
  localparam logic [1:0] INIT_RX = 2'h2;
  localparam logic [1:0] DEV_1 = 2'h1;
  // FIFO shape and clock settling
  localparam int FIFO_AW = 5;
  localparam logic [5:0] FIFO_DEPTH = 6'h20;
  localparam logic [7:0] SETTLE_CYCLES = 8'h10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_LOAD = 3'b010,
    ST_SHIFT = 3'b011,
    ST_STORE = 3'b100
  } qsf_state_t;
  // Bit slots per byte for a lane width
  function automatic logic [3:0] slots(input logic [1:0] lane);
    slots = (lane == LANE_QUAD) ? 4'h2 : (lane == LANE_DUAL) ? 4'h4 : 4'h8;
  endfunction
  // Bits presented on the data lines
  function automatic logic [3:0] out_bits(input logic [7:0] sh, input logic [1:0] lane, input logic low_bit_first);
    case (lane)
      LANE_DUAL: out_bits = {2'h0, low_bit_first ? sh[1:0] : sh[7:6]};
      LANE_QUAD: out_bits = low_bit_first ? sh[3:0] : sh[7:4];
      default: out_bits = {3'h0, low_bit_first ? sh[0] : sh[7]};
    endcase
  endfunction
  // Advance the outgoing byte by one slot
  function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic [1:0] lane, input logic low_bit_first);
    case (lane)
      LANE_DUAL: shift_out = low_bit_first ? {2'h0, sh[7:2]} : {sh[5:0], 2'h0};
      LANE_QUAD: shift_out = low_bit_first ? {4'h0, sh[7:4]} : {sh[3:0], 4'h0};
      default: shift_out = low_bit_first ? {1'h0, sh[7:1]} : {sh[6:0], 1'h0};
    endcase
  endfunction
  // Merge one sampled slot into the incoming byte
  function automatic logic [7:0] in_merge(input logic [7:0] sh, input logic [3:0] d, input logic [1:0] lane,
                                          input logic low_bit_first);
    case (lane)
      LANE_DUAL: in_merge = low_bit_first ? {d[1:0], sh[7:2]} : {sh[5:0], d[1:0]};
      LANE_QUAD: in_merge = low_bit_first ? {d, sh[7:4]} : {sh[3:0], d};
      default: in_merge = low_bit_first ? {d[1], sh[7:1]} : {sh[6:0], d[1]};
    endcase
  endfunction
endpackage

// >>> qsf_fifo.sv
`timescale 1ns/10ps
module qsf_fifo
  import qsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic push_i,
  input wire logic [7:0] wdata_i,
  input wire logic pop_i,
  output logic [7:0] rdata_o,
  output logic [5:0] count_o
);
  logic [7:0] mem [0:31];
  logic [FIFO_AW-1:0] wptr;
  logic [FIFO_AW-1:0] rptr;
  // Full and empty pushes and pops are dropped
  wire do_push = push_i & (count_o != FIFO_DEPTH);
  wire do_pop = pop_i & (count_o != 6'h00);

  // Storage has no reset; head word is re-registered every cycle
  always_ff @(posedge clk_i) begin
    if (ce_i && do_push) begin
      mem[wptr] <= wdata_i;
    end
    if (ce_i) begin
      rdata_o <= mem[rptr];
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr <= '0;
      rptr <= '0;
      count_o <= 6'h00;
    end else if (ce_i) begin
      if (clr_i) begin
        wptr <= '0;
        rptr <= '0;
        count_o <= 6'h00;
      end else begin
        wptr <= wptr + FIFO_AW'(do_push);
        rptr <= rptr + FIFO_AW'(do_pop);
        count_o <= count_o + 6'(do_push) - 6'(do_pop);
      end
    end
  end
endmodule

// >>> qsf_serial_clock_divider.sv
`timescale 1ns/10ps
module qsf_serial_clock_divider
  import qsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] div_i,
  output logic tick_o,
  output logic stable_o
);
  logic [8:0] cnt;
  logic [7:0] settle;
  logic [8:0] half;

  // Half period in base cycles, highest set bit wins
  always_comb begin
    half = 9'h001;
    for (int k = 0; k < 8; k++) begin
      if (div_i[k]) begin
        half = 9'h002 << k; // see R18
      end
    end
  end

  // Tick per half period; stable after a fixed settling count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 9'h000;
      tick_o <= 1'b0;
      settle <= 8'h00;
      stable_o <= 1'b0;
    end else if (ce_i) begin
      if (!en_i || clr_i) begin
        cnt <= 9'h000; // see R20
        tick_o <= 1'b0;
        settle <= 8'h00;
        stable_o <= 1'b0;
      end else begin
        tick_o <= (cnt >= half - 9'h001);
        cnt <= (cnt >= half - 9'h001) ? 9'h000 : cnt + 9'h001;
        settle <= (settle == SETTLE_CYCLES) ? settle : settle + 8'h01;
        stable_o <= (settle == SETTLE_CYCLES); // see R19
      end
    end
  end

  property p_div4;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (tick_o && en_i && div_i == 8'h01 && !clr_i) ##1 (en_i && div_i == 8'h01 && !clr_i) |-> !tick_o [*3] ##1 tick_o;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 tick spacing wrong"); // see R18

  property p_stop;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      !en_i |=> (!stable_o && !tick_o);
  endproperty
  a_stop: assert property (p_stop) else $error("clock runs while disabled"); // see R20

  property p_stable;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      stable_o |-> (settle == SETTLE_CYCLES && $past(en_i));
  endproperty
  a_stable: assert property (p_stable) else $error("stable flag before settling"); // see R19
endmodule

// >>> qsf_ctrl.sv
`timescale 1ns/10ps
module qsf_ctrl
  import qsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic serial_clock_pin_o,
  output logic [1:0] chip_select_n_o,
  output logic [3:0] data_line_o,
  output logic [3:0] data_line_oe_n_o,
  input wire logic [3:0] data_line_i
);
  logic [31:0] cfg;
  logic [31:0] xfer;
  logic [7:0] clk_div;
  logic clk_en;
  logic [4:0] tx_thr;
  logic [4:0] rx_thr;
  logic sw_rst;
  logic [15:0] remaining;
  qsf_state_t state;
  logic [7:0] sh_out;
  logic [7:0] sh_in;
  logic [3:0] bit_left;
  logic half;
  logic first;
  logic sclk_q;
  logic dir_tx;
  logic cs_active;
  logic [3:0] din_s1;
  logic [3:0] din_s2;
  logic tick;
  logic clk_stable;
  logic [7:0] tx_rdata;
  logic [7:0] rx_rdata;
  logic [5:0] tx_cnt;
  logic [5:0] rx_cnt;

  // Bus decode
  wire acc = psel_i & penable_i;
  wire done = acc & pready_o;
  wire wr = done & pwrite_i;
  wire rd = done & ~pwrite_i;
  wire hit_cfg = paddr_i == OFS_CFG;
  wire hit_xfer = paddr_i == OFS_XFER;
  wire hit_clk = paddr_i == OFS_CLK;
  wire hit_thr = paddr_i == OFS_THR;
  wire hit_txd = paddr_i == OFS_TXD;
  wire hit_rxd = paddr_i == OFS_RXD;
  wire hit_stat = paddr_i == OFS_STAT;
  wire mapped = hit_cfg | hit_xfer | hit_clk | hit_thr | hit_txd | hit_rxd | hit_stat;

  // Field views
  wire [2:0] mode = cfg[CFG_MODE_LSB +: 3];
  wire [1:0] lane = xfer[XF_LANE_LSB +: 2]; // see R13
  wire [1:0] init = xfer[XF_INIT_LSB +: 2]; // see R14
  wire [1:0] dev = xfer[XF_DEV_LSB +: 2];
  wire flash = cfg[CFG_FLASH];
  wire clock_phase = cfg[CFG_CLOCK_PHASE];
  wire low_bit_first = cfg[CFG_LOW_BIT_FIRST];
  wire rx_latch = cfg[CFG_RXL];
  wire [2:0] wr_mode = pwdata_i[CFG_MODE_LSB +: 3];
  // XIP is only left towards CPU mode
  wire [2:0] next_mode = (mode == MODE_XIP && wr_mode != MODE_XIP) ? MODE_CPU : wr_mode; // see R9

  // Read data views
  wire [31:0] cfg_rd = cfg | ({31'h0, sw_rst} << CFG_RST);
  wire [31:0] clk_rd = {16'h0, clk_div, 6'h0, clk_stable, clk_en};
  wire [31:0] thr_rd = {19'h0, tx_thr, 3'h0, rx_thr};
  wire [31:0] stat_rd = {10'h0, rx_cnt, 2'h0, tx_cnt, 6'h0, cs_active, state != ST_IDLE};
  wire [31:0] rd_mux = hit_cfg ? cfg_rd :
                       hit_xfer ? xfer :
                       hit_clk ? clk_rd :
                       hit_thr ? thr_rd :
                       hit_rxd ? {24'h0, rx_rdata} :
                       hit_stat ? stat_rd : 32'h0;

  // Start qualifiers
  // XIP runs on the same programmed timing as the other modes
  wire mode_ok = mode == MODE_CPU || mode == MODE_DMA || mode == MODE_XIP; // see R8 R10
  wire cfg_ok = mode_ok && lane != 2'h3 && dev <= DEV_1 && init != 2'h3; // see R25
  wire [5:0] rx_free = FIFO_DEPTH - rx_cnt;
  wire [5:0] tx_need = (tx_thr == 5'h00) ? 6'h01 : {1'b0, tx_thr};
  wire [5:0] rx_need = (rx_thr == 5'h00) ? 6'h01 : {1'b0, rx_thr};
  wire go_tx = init == INIT_TX && remaining != 16'h0000 &&
               (cs_active ? tx_cnt != 6'h00 : tx_cnt >= tx_need); // see R15 R21
  wire go_rx = init == INIT_RX && remaining != 16'h0000 &&
               (cs_active ? rx_free != 6'h00 : rx_free >= rx_need); // see R16 R22
  wire can_go = cfg_ok && clk_stable;
  wire idle_lvl = flash ? 1'b1 : cfg[CFG_CLOCK_POLARITY]; // see R3 R6

  // Edge roles within a bit slot
  wire a_ph = tick & ~half;
  wire b_ph = tick & half;
  wire do_sample = (a_ph & (flash | ~clock_phase)) | (b_ph & ~flash & clock_phase); // see R3 R7
  wire do_shift = (a_ph & (flash | clock_phase) & ~first) | (b_ph & ~flash & ~clock_phase & (bit_left != 4'h1)); // see R7
  wire tx_pop = state == ST_LOAD;
  wire tx_push = wr & hit_txd;
  wire rx_pop = rd & hit_rxd;
  wire rx_push = state == ST_STORE && (!dir_tx || rx_latch) && rx_free != 6'h00; // see R4

  // Pin values before the output flops
  wire [3:0] ob = out_bits(sh_out, lane, low_bit_first); // see R5
  wire drive_tx = state != ST_IDLE && dir_tx;
  wire [1:0] ctl_bits = {cfg[CFG_HOLD], cfg[CFG_WP]};
  wire [3:0] next_dout = (lane == LANE_QUAD) ? ob : {ctl_bits, ob[1:0]}; // see R1 R2
  wire [3:0] next_oe_n = (lane == LANE_SINGLE) ? 4'h2 :
                         (lane == LANE_DUAL) ? {2'h0, drive_tx ? 2'h0 : 2'h3} :
                         (lane == LANE_QUAD && drive_tx) ? 4'h0 : 4'hF;
  wire [1:0] next_cs_n = cs_active ? ~(2'h1 << dev) : 2'h3; // see R12

  qsf_serial_clock_divider u_serial_clock_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(sw_rst),
    .en_i(clk_en),
    .div_i(clk_div),
    .tick_o(tick),
    .stable_o(clk_stable)
  );

  qsf_fifo u_txf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(sw_rst),
    .push_i(tx_push),
    .wdata_i(pwdata_i[7:0]),
    .pop_i(tx_pop),
    .rdata_o(tx_rdata),
    .count_o(tx_cnt)
  );

  qsf_fifo u_rxf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(sw_rst),
    .push_i(rx_push),
    .wdata_i(sh_in),
    .pop_i(rx_pop),
    .rdata_o(rx_rdata),
    .count_o(rx_cnt)
  );

  // Bus answer one cycle into the access phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= acc & ~pready_o;
      pslverr_o <= acc & ~pready_o & ~mapped;
      if (acc && !pready_o) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // Software registers; reset bit reads back as its own pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= REG_RST_VAL;
      xfer <= REG_RST_VAL;
      clk_div <= 8'h00;
      clk_en <= 1'b0;
      tx_thr <= 5'h00;
      rx_thr <= 5'h00;
      sw_rst <= 1'b0;
    end else if (ce_i) begin
      sw_rst <= wr && hit_cfg && pwdata_i[CFG_RST]; // see R24
      if (wr && hit_cfg) begin
        cfg <= ((pwdata_i & CFG_WMASK) & ~32'h00000007) | {29'h0, next_mode};
      end
      if (wr && hit_xfer) begin
        xfer <= pwdata_i & XF_WMASK;
      end
      if (wr && hit_clk) begin
        clk_div <= pwdata_i[CK_DIV_LSB +: 8];
        clk_en <= pwdata_i[CK_EN];
      end
      if (wr && hit_thr) begin
        tx_thr <= pwdata_i[TH_TX_LSB +: 5];
        rx_thr <= pwdata_i[TH_RX_LSB +: 5];
      end
    end
  end

  // Byte budget; a fresh count from software wins over a decrement
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      remaining <= 16'h0000;
    end else if (ce_i) begin
      if (sw_rst) begin
        remaining <= 16'h0000;
      end else if (wr && hit_xfer) begin
        remaining <= pwdata_i[XF_CNT_LSB +: 16]; // see R17
      end else if (state == ST_STORE) begin
        remaining <= remaining - 16'h0001;
      end
    end
  end

  // Pin inputs cross in through two flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      din_s1 <= 4'h0;
      din_s2 <= 4'h0;
    end else if (ce_i) begin
      din_s1 <= data_line_i;
      din_s2 <= din_s1;
    end
  end

  // Byte engine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      sh_out <= 8'h00;
      sh_in <= 8'h00;
      bit_left <= 4'h0;
      half <= 1'b0;
      first <= 1'b1;
      sclk_q <= 1'b0;
      dir_tx <= 1'b0;
      cs_active <= 1'b0;
    end else if (ce_i) begin
      if (sw_rst) begin
        state <= ST_IDLE; // see R24
        sh_out <= 8'h00;
        bit_left <= 4'h0;
        half <= 1'b0;
        first <= 1'b1;
        sclk_q <= idle_lvl;
        cs_active <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sclk_q <= idle_lvl; // see R6
            half <= 1'b0;
            first <= 1'b1;
            if (can_go && go_tx) begin
              state <= ST_FETCH;
              dir_tx <= 1'b1;
              cs_active <= 1'b1;
            end else if (can_go && go_rx) begin
              state <= ST_SHIFT;
              dir_tx <= 1'b0;
              cs_active <= 1'b1;
              sh_out <= 8'h00;
              bit_left <= slots(lane);
            end else if (cs_active && remaining == 16'h0000 && xfer[XF_REL]) begin
              cs_active <= 1'b0; // see R11
            end
          end
          ST_FETCH: begin
            state <= ST_LOAD;
          end
          ST_LOAD: begin
            sh_out <= tx_rdata;
            bit_left <= slots(lane);
            state <= ST_SHIFT;
          end
          ST_SHIFT: begin
            if (tick) begin
              sclk_q <= ~sclk_q;
              half <= ~half;
              if (do_shift) begin
                sh_out <= shift_out(sh_out, lane, low_bit_first); // see R5
              end
              if (do_sample) begin
                sh_in <= in_merge(sh_in, din_s2, lane, low_bit_first);
              end
              if (half) begin
                first <= 1'b0;
                if (bit_left == 4'h1) begin
                  state <= ST_STORE;
                end else begin
                  bit_left <= bit_left - 4'h1;
                end
              end
            end
          end
          ST_STORE: begin
            state <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Output flops; every pin is registered to keep edges clean
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_clock_pin_o <= 1'b0;
      chip_select_n_o <= 2'h3;
      data_line_o <= 4'h0;
      data_line_oe_n_o <= 4'hF;
    end else if (ce_i) begin
      serial_clock_pin_o <= sclk_q;
      chip_select_n_o <= next_cs_n;
      data_line_o <= next_dout;
      data_line_oe_n_o <= next_oe_n;
    end
  end

  property p_wp_line;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (lane == LANE_SINGLE || lane == LANE_DUAL) |=> (data_line_o[2] == $past(cfg[CFG_WP]) && !data_line_oe_n_o[2]);
  endproperty
  a_wp_line: assert property (p_wp_line) else $error("line 2 not driven from write protect"); // see R1

  property p_hold_line;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (lane == LANE_SINGLE || lane == LANE_DUAL) |=> (data_line_o[3] == $past(cfg[CFG_HOLD]) && !data_line_oe_n_o[3]);
  endproperty
  a_hold_line: assert property (p_hold_line) else $error("line 3 not driven from hold"); // see R2

  property p_idle_clk;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == ST_IDLE && !sw_rst) ##1 ce_i |=> serial_clock_pin_o == $past(idle_lvl, 2);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong"); // see R6

  property p_release;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == ST_IDLE && cs_active && remaining == 16'h0000 && xfer[XF_REL] && !sw_rst) |=> ##1 chip_select_n_o == 2'h3;
  endproperty
  a_release: assert property (p_release) else $error("chip select not released"); // see R11

  property p_soft_reset;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      sw_rst |=> (!sw_rst && state == ST_IDLE && tx_cnt == 6'h00 && rx_cnt == 6'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear"); // see R24

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == ST_IDLE && !cfg_ok) |=> state == ST_IDLE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("transfer started on reserved code"); // see R25

  property p_rx_room;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == ST_IDLE && !cs_active && !sw_rst) ##1 (state == ST_SHIFT) |-> $past(rx_free) >= $past(rx_need);
  endproperty
  a_rx_room: assert property (p_rx_room) else $error("receive without room"); // see R22

  property p_tx_thr;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == ST_IDLE && !cs_active && !sw_rst) ##1 (state == ST_FETCH) |-> $past(tx_cnt) >= $past(tx_need);
  endproperty
  a_tx_thr: assert property (p_tx_thr) else $error("transmit below threshold"); // see R21

  property p_no_latch;
    @(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == ST_STORE && dir_tx && !rx_latch && !sw_rst && !rx_pop) |=> rx_cnt == $past(rx_cnt);
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("transmit data latched while disabled"); // see R4
endmodule

// >>> qsf_flash_model.sv
`timescale 1ns/10ps
module qsf_flash_model #(
  parameter logic [7:0] ANSWER = 8'h3A
) (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic d0_i,
  output logic d1_o,
  output logic [7:0] got_o
);
  logic [7:0] resp;
  logic cs_q;
  initial begin
    d1_o = 1'b0;
    got_o = 8'h00;
    resp = 8'h00;
    cs_q = 1'b1;
  end
  // Host bits sampled on the rising clock edge while selected
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      got_o <= {got_o[6:0], d0_i};
    end
  end
  // Answer goes out high bit first; a released line flips so stale data never looks valid
  always @(negedge sclk_i or cs_n_i) begin
    if (cs_n_i) begin
      d1_o <= ~d1_o;
    end else if (cs_q) begin
      d1_o <= ANSWER[7];
      resp <= {ANSWER[6:0], 1'b0};
    end else begin
      d1_o <= resp[7];
      resp <= {resp[6:0], 1'b0};
    end
    cs_q <= cs_n_i;
  end
endmodule

// >>> qsf_tb.sv
`timescale 1ns/10ps
module testbench;
  import qsf_pkg::*;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, sclk, d1, e;
  logic [7:0] paddr, got;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0] cs_n;
  logic [3:0] dl_o, oe_n, dl_i;
  int n_mismatch = 0;
  int compares = 0;
  // Undriven lines read high through pull-ups; line 1 comes from the flash
  assign dl_i = (dl_o & ~oe_n) | ({2'b11, d1, 1'b1} & oe_n);
  qsf_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .serial_clock_pin_o(sclk), .chip_select_n_o(cs_n), .data_line_o(dl_o),
    .data_line_oe_n_o(oe_n), .data_line_i(dl_i));
  qsf_flash_model i_flash (.sclk_i(sclk), .cs_n_i(cs_n[0]), .d0_i(dl_i[0]), .d1_o(d1), .got_o(got));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("FAIL at %0t got %h expected %h", $time, g, x);
    end
  endtask
  // One APB transfer, held until pready is seen, with a bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_mismatch++;
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdv, x);
  endtask
  task automatic wait_cs(input logic v);
    int n;
    n = 0;
    while (cs_n[0] !== v && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    chk(cs_n[0], v);
  endtask
  task automatic t_reset();
    rd(OFS_CFG, 32'h0);
    rd(OFS_XFER, 32'h0);
    rd(OFS_CLK, 32'h0);
    rd(OFS_THR, 32'h0);
    rd(8'h1C, 32'h0);
    chk(e, 1'b1);
  endtask
  task automatic t_pins();
    wr(OFS_CFG, 32'h00000211);
    repeat (3) @(posedge clk_i);
    chk({oe_n[3:2], dl_o[3:2], sclk}, 5'h03);
    wr(OFS_CFG, 32'h00000401);
    repeat (3) @(posedge clk_i);
    chk({oe_n[3:2], dl_o[3:2], sclk}, 5'h04);
  endtask
  task automatic t_clock();
    wr(OFS_CLK, 32'h00000401);
    rd(OFS_CLK, 32'h00000401);
    repeat (20) @(posedge clk_i);
    rd(OFS_CLK, 32'h00000403);
  endtask
  // One byte out on line 0 while the answer comes back on line 1
  task automatic t_xfer(input logic lsb, input logic [7:0] wire_x, input logic [7:0] rx_x);
    int h;
    h = 0;
    wr(OFS_CFG, {26'h0, lsb, 5'h01} | 32'h80);
    wr(OFS_THR, 32'h00000100);
    wr(OFS_XFER, 32'h00410001);
    wr(OFS_TXD, 32'h000000C4);
    wait_cs(1'b0);
    while (sclk !== 1'b1) @(posedge clk_i);
    while (sclk === 1'b1 && h < 100) begin
      @(posedge clk_i);
      h++;
    end
    chk(h, 8);
    wait_cs(1'b1);
    chk(got, wire_x);
    rd(OFS_RXD, {24'h0, rx_x});
  endtask
  // One byte fetched in receive initiation, high bit first
  task automatic t_rx();
    wr(OFS_CFG, 32'h00000081);
    wr(OFS_XFER, 32'h00420001);
    wait_cs(1'b0);
    wait_cs(1'b1);
    rd(OFS_RXD, 32'h0000003A);
  endtask
  task automatic t_reserved();
    wr(OFS_XFER, 32'h004D0001);
    wr(OFS_TXD, 32'h00000055);
    repeat (100) @(posedge clk_i);
    chk(cs_n, 2'b11);
    rd(OFS_STAT, 32'h00000100);
    wr(OFS_CFG, 32'h00010081);
    rd(OFS_STAT, 32'h0);
  endtask
  task automatic t_xip();
    wr(OFS_CFG, 32'h00000003);
    rd(OFS_CFG, 32'h00000003);
    wr(OFS_CFG, 32'h00000002);
    rd(OFS_CFG, 32'h00000001);
  endtask
  task automatic give_verdict();
    $display("Mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset, then the scenarios in order
  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pins();
    t_clock();
    t_xfer(1'b0, 8'hC4, 8'h3A);
    t_xfer(1'b1, 8'h23, 8'h5C);
    t_rx();
    t_reserved();
    t_xip();
    give_verdict();
  end
  // Whole run is under a thousand cycles; this cuts a hang short
  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
endmodule
